// [rtl/tap_prog_pkg.sv]
/*
 * Constants and types for the serial configuration programming port:
 * instruction codes, shift path lengths and controller states.
 * Assumes a single 6-bit instruction register and one shared scan path.
 */
package tap_prog_pkg;

    localparam int IR_LEN     = 6;
    localparam int SR_LEN     = 81;
    localparam int LEN_W      = 7;
    localparam int LA_ADDR_W  = 75;
    localparam int LA_DATA_W  = 81;
    localparam int CA_ADDR_W  = 4;
    localparam int CA_DATA_W  = 41;
    localparam int STATUS_W   = 12;
    localparam int SIG_W      = 16;
    localparam int ID_W       = 32;
    localparam int SYNC_W     = 3;
    // Count of rising test clock edges in idle; an operation fires on this one
    localparam logic [1:0] RTI_FIRE_EDGE = 2'h2;

    // Scan path lengths
    localparam logic [LEN_W-1:0] LEN_BYPASS  = 7'h01;
    localparam logic [LEN_W-1:0] LEN_LA_ADDR = 7'h4B;
    localparam logic [LEN_W-1:0] LEN_LA_DATA = 7'h51;
    localparam logic [LEN_W-1:0] LEN_CA_ADDR = 7'h04;
    localparam logic [LEN_W-1:0] LEN_CA_DATA = 7'h29;
    localparam logic [LEN_W-1:0] LEN_ID      = 7'h20;
    localparam logic [LEN_W-1:0] LEN_STATUS  = 7'h0C;
    localparam logic [LEN_W-1:0] LEN_SIG     = 7'h10;

    // Instruction codes
    localparam logic [5:0] OP_EXTEST          = 6'h00;
    localparam logic [5:0] OP_LA_ADDR_SELECT  = 6'h01;
    localparam logic [5:0] OP_LA_DATA_SELECT  = 6'h02;
    localparam logic [5:0] OP_AND_ERASE       = 6'h03;
    localparam logic [5:0] OP_ARCH_ERASE      = 6'h04;
    localparam logic [5:0] OP_LOGIC_COL_PROG  = 6'h05;
    localparam logic [5:0] OP_FUSE_PROG       = 6'h06;
    localparam logic [5:0] OP_BYPASS          = 6'h07;
    localparam logic [5:0] OP_LOGIC_COL_READ  = 6'h08;
    localparam logic [5:0] OP_DISCHARGE       = 6'h09;
    localparam logic [5:0] OP_CA_ADDR_SELECT  = 6'h0A;
    localparam logic [5:0] OP_CA_DATA_SELECT  = 6'h0B;
    localparam logic [5:0] OP_CFG_ERASE       = 6'h0C;
    localparam logic [5:0] OP_CFG_COL_PROG    = 6'h0D;
    localparam logic [5:0] OP_CFG_COL_READ    = 6'h0E;
    localparam logic [5:0] OP_FULL_ERASE      = 6'h16;
    localparam logic [5:0] OP_SAFE_HOLD       = 6'h17;
    localparam logic [5:0] OP_PROG_ENTER      = 6'h18;
    localparam logic [5:0] OP_IDCODE         = 6'h19;
    localparam logic [5:0] OP_PROG_EXIT       = 6'h1A;
    localparam logic [5:0] OP_STATUS_SELECT   = 6'h1B;
    localparam logic [5:0] OP_SAMPLE          = 6'h1C;
    localparam logic [5:0] OP_SIG_ERASE       = 6'h1D;
    localparam logic [5:0] OP_SIG_SHIFT       = 6'h1E;
    localparam logic [5:0] OP_SIG_PROG        = 6'h1F;

    typedef enum logic [15:0] {
        st_reset    = 16'h0001,
        st_idle     = 16'h0002,
        st_sel_dr   = 16'h0004,
        st_cap_dr   = 16'h0008,
        st_shift_dr = 16'h0010,
        st_ex1_dr   = 16'h0020,
        st_pause_dr = 16'h0040,
        st_ex2_dr   = 16'h0080,
        st_upd_dr   = 16'h0100,
        st_sel_ir   = 16'h0200,
        st_cap_ir   = 16'h0400,
        st_shift_ir = 16'h0800,
        st_ex1_ir   = 16'h1000,
        st_pause_ir = 16'h2000,
        st_ex2_ir   = 16'h4000,
        st_upd_ir   = 16'h8000
    } tap_state_type;

endpackage

// [rtl/tap_prog_port.sv]
/*
 * Serial test access port that programs and checks the nonvolatile
 * configuration memory: 16-state controller, 6-bit instruction register,
 * bypass, identification, address, data, status and signature paths.
 * Assumes the test pins arrive asynchronously and that ref_clk runs well
 * above four times the test clock; memory ports are on ref_clk.
 */
// Behaviour
// - Inputs sampled on tck rise; tdo changes on tck fall.
// - Sixteen-state controller stepped by tms sampled at each rise.
// - Tms held high reaches the reset state within five tck rises.
// - Power-up in reset state; leaving it goes to idle.
// - Capture data parallel-loads the path chosen by the instruction.
// - Capture-IR loads identity code; default data scan reads identity.
// - Capture, shift, exit1, pause, exit2, update in standard order.
// - Program, erase, verify, discharge start at next idle; others act at update.
// - Instruction register is six bits; six bits per instruction scan.
// - Code 000111 and top-bit-set codes select one-bit bypass.
// - External-test and sample/preload codes act exactly as bypass.
// - Identity code selects 32-bit identity path; outputs stay normal outside programming mode.
// - Identity readable right after power-up or reset state.
// - Array access and operation codes hold outputs safe.
// - Safe hold: open drains released, gate drivers forced low.
// - Code 011000 enters programming mode; 011010 leaves it.
// - Logic array: 75-bit address, 81-bit data, program, read.
// - Config array: 4-bit address, 41-bit data, program, read.
// - Bulk erase of AND, architecture, config, signature; full erase.
// - Security fuse program and voltage discharge instructions.
// - Status code connects 12-bit comparator status path.
// - Signature shift loads stored 16 bits; companion programs back.
// - Erase and program fire at second idle rise, mode enabled.
// - Entering reset state cancels programming mode like exit code.
// - Status code latches comparator outputs in capture data.
`timescale 1ns/1ns
`default_nettype none

module tap_prog_port
    import tap_prog_pkg::*;
#(
    // Arbitrary identity value, no meaning beyond this design
    parameter logic [ID_W-1:0] ID_VALUE = 32'h0000_1001
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    // Test pins
    input  wire logic                 tck,
    input  wire logic                 tms,
    input  wire logic                 tdi,
    output logic                      tdo,
    output logic                      tdo_oe_n,
    // Analog monitor results
    input  wire logic [STATUS_W-1:0]  comparator_status,
    // Nonvolatile memory side
    input  wire logic [LA_DATA_W-1:0] logic_read_data,
    input  wire logic [CA_DATA_W-1:0] config_read_data,
    input  wire logic [SIG_W-1:0]     user_signature_stored,
    output logic [LA_ADDR_W-1:0]      logic_address,
    output logic [LA_DATA_W-1:0]      logic_data,
    output logic [CA_ADDR_W-1:0]      config_address,
    output logic [CA_DATA_W-1:0]      config_data,
    output logic [SIG_W-1:0]          user_signature,
    output logic [5:0]                nvm_op_code,
    output logic                      nvm_op_pulse,
    // Device output control
    output logic                      programming_mode,
    output logic                      outputs_safe_hold
);

    typedef struct packed {
        logic [SYNC_W-1:0]    tck_s;
        logic [SYNC_W-1:0]    tms_s;
        logic [SYNC_W-1:0]    tdi_s;
        logic [SYNC_W-1:0][STATUS_W-1:0] cmp_s;
        logic                 tck_f;
        logic                 tms_f;
        logic                 tdi_f;
        logic [STATUS_W-1:0]  cmp_f;
        tap_state_type        tap;
        logic [IR_LEN-1:0]    ir_sr;
        logic [IR_LEN-1:0]    ir;
        logic [SR_LEN-1:0]    sr;
        logic [LA_ADDR_W-1:0] la_addr;
        logic [LA_DATA_W-1:0] la_data;
        logic [CA_ADDR_W-1:0] ca_addr;
        logic [CA_DATA_W-1:0] ca_data;
        logic [SIG_W-1:0]     sig;
        logic                 prog;
        logic                 armed;
        logic [1:0]           rti_cnt;
        logic [5:0]           op_code;
        logic                 op_pulse;
        logic                 tdo;
        logic                 tdo_oe_n;
        logic                 safe;
    } state_type;

    localparam state_type RESET_STATE = '{
        tap:      st_reset,
        ir:       OP_IDCODE,
        tdo_oe_n: 1'b1,
        default:  '0
    };

    state_type s_q;
    state_type s_d;

    // Level filter: a bit changes only when stages two and three agree
    function automatic logic [STATUS_W-1:0] filt(
        input logic [STATUS_W-1:0] s2,
        input logic [STATUS_W-1:0] s3,
        input logic [STATUS_W-1:0] cur);
        filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & cur);
    endfunction

    function automatic logic [LEN_W-1:0] dr_len(input logic [5:0] op);
        unique case (op)
            OP_LA_ADDR_SELECT:                    dr_len = LEN_LA_ADDR;
            OP_LA_DATA_SELECT, OP_LOGIC_COL_READ: dr_len = LEN_LA_DATA;
            OP_CA_ADDR_SELECT:                    dr_len = LEN_CA_ADDR;
            OP_CA_DATA_SELECT, OP_CFG_COL_READ:   dr_len = LEN_CA_DATA;
            OP_IDCODE:                            dr_len = LEN_ID;
            OP_STATUS_SELECT:                     dr_len = LEN_STATUS;
            OP_SIG_SHIFT:                         dr_len = LEN_SIG;
            default: dr_len = LEN_BYPASS;
        endcase
    endfunction

    // Operations that run in idle; a read is the verify step
    function automatic logic runs_in_idle(input logic [5:0] op);
        runs_in_idle = op inside {OP_AND_ERASE, OP_ARCH_ERASE,
            OP_LOGIC_COL_PROG, OP_FUSE_PROG, OP_LOGIC_COL_READ,
            OP_DISCHARGE, OP_CFG_ERASE, OP_CFG_COL_PROG, OP_CFG_COL_READ,
            OP_FULL_ERASE, OP_SIG_ERASE, OP_SIG_PROG};
    endfunction

    function automatic logic needs_prog(input logic [5:0] op);
        needs_prog = op inside {OP_AND_ERASE, OP_ARCH_ERASE,
            OP_LOGIC_COL_PROG, OP_FUSE_PROG, OP_CFG_ERASE, OP_CFG_COL_PROG,
            OP_FULL_ERASE, OP_SIG_ERASE, OP_SIG_PROG};
    endfunction

    function automatic logic holds_safe(input logic [5:0] op);
        holds_safe = runs_in_idle(op) | (op inside {OP_LA_ADDR_SELECT,
            OP_LA_DATA_SELECT, OP_CA_ADDR_SELECT, OP_CA_DATA_SELECT,
            OP_SAFE_HOLD, OP_PROG_ENTER});
    endfunction

    function automatic tap_state_type tap_next(input tap_state_type st,
                                               input logic m);
        unique case (st)
            st_reset:    tap_next = m ? st_reset    : st_idle;
            st_idle:     tap_next = m ? st_sel_dr   : st_idle;
            st_sel_dr:   tap_next = m ? st_sel_ir   : st_cap_dr;
            st_cap_dr:   tap_next = m ? st_ex1_dr   : st_shift_dr;
            st_shift_dr: tap_next = m ? st_ex1_dr   : st_shift_dr;
            st_ex1_dr:   tap_next = m ? st_upd_dr   : st_pause_dr;
            st_pause_dr: tap_next = m ? st_ex2_dr   : st_pause_dr;
            st_ex2_dr:   tap_next = m ? st_upd_dr   : st_shift_dr;
            st_upd_dr:   tap_next = m ? st_sel_dr   : st_idle;
            st_sel_ir:   tap_next = m ? st_reset    : st_cap_ir;
            st_cap_ir:   tap_next = m ? st_ex1_ir   : st_shift_ir;
            st_shift_ir: tap_next = m ? st_ex1_ir   : st_shift_ir;
            st_ex1_ir:   tap_next = m ? st_upd_ir   : st_pause_ir;
            st_pause_ir: tap_next = m ? st_ex2_ir   : st_pause_ir;
            st_ex2_ir:   tap_next = m ? st_upd_ir   : st_shift_ir;
            st_upd_ir:   tap_next = m ? st_sel_dr   : st_idle;
            default:     tap_next = st_reset;
        endcase
    endfunction

    always_comb begin
        logic       rise;
        logic       fall;
        logic [LEN_W-1:0] len;
        rise = 1'b0;
        fall = 1'b0;
        len  = dr_len(s_q.ir);
        s_d  = s_q;
        s_d.op_pulse = 1'b0;

        // Three-stage synchronisers; only stages two and three are read
        s_d.tck_s = {s_q.tck_s[1:0], tck};
        s_d.tms_s = {s_q.tms_s[1:0], tms};
        s_d.tdi_s = {s_q.tdi_s[1:0], tdi};
        s_d.cmp_s = {s_q.cmp_s[1:0], comparator_status};
        s_d.tck_f = (s_q.tck_s[1] == s_q.tck_s[2]) ? s_q.tck_s[2] : s_q.tck_f;
        s_d.tms_f = (s_q.tms_s[1] == s_q.tms_s[2]) ? s_q.tms_s[2] : s_q.tms_f;
        s_d.tdi_f = (s_q.tdi_s[1] == s_q.tdi_s[2]) ? s_q.tdi_s[2] : s_q.tdi_f;
        s_d.cmp_f = filt(s_q.cmp_s[1], s_q.cmp_s[2], s_q.cmp_f);
        rise = s_d.tck_f & ~s_q.tck_f;
        fall = ~s_d.tck_f & s_q.tck_f;

        // Filtered levels settle no later than the clock, so they are stable
        if (rise) begin
            s_d.tap = tap_next(s_q.tap, s_d.tms_f);
            unique case (s_q.tap)
                st_idle: begin
                    s_d.rti_cnt = s_q.rti_cnt + 2'h1;
                    if (s_q.armed && s_d.rti_cnt == RTI_FIRE_EDGE) begin
                        s_d.armed = 1'b0;
                        if (s_q.prog || !needs_prog(s_q.ir)) begin
                            s_d.op_code  = s_q.ir;
                            s_d.op_pulse = 1'b1;
                        end
                    end
                end
                st_cap_ir: s_d.ir_sr = OP_IDCODE;
                st_shift_ir: begin
                    s_d.ir_sr = {s_d.tdi_f, s_q.ir_sr[IR_LEN-1:1]};
                end
                st_upd_ir: begin
                    s_d.ir      = s_q.ir_sr;
                    s_d.armed   = runs_in_idle(s_q.ir_sr);
                    s_d.rti_cnt = 2'h0;
                    if (s_q.ir_sr == OP_PROG_ENTER) begin
                        s_d.prog = 1'b1;
                    end
                    if (s_q.ir_sr == OP_PROG_EXIT) begin
                        s_d.prog = 1'b0;
                    end
                end
                st_cap_dr: begin
                    s_d.sr = '0;
                    unique case (s_q.ir)
                        OP_LA_ADDR_SELECT: s_d.sr[LA_ADDR_W-1:0] = s_q.la_addr;
                        OP_LA_DATA_SELECT,
                        OP_LOGIC_COL_READ: s_d.sr = logic_read_data;
                        OP_CA_ADDR_SELECT: s_d.sr[CA_ADDR_W-1:0] = s_q.ca_addr;
                        OP_CA_DATA_SELECT,
                        OP_CFG_COL_READ: begin
                            s_d.sr[CA_DATA_W-1:0] = config_read_data;
                        end
                        OP_IDCODE:  s_d.sr[ID_W-1:0] = ID_VALUE;
                        OP_STATUS_SELECT: begin
                            s_d.sr[STATUS_W-1:0] = s_q.cmp_f;
                        end
                        OP_SIG_SHIFT: begin
                            s_d.sr[SIG_W-1:0] = user_signature_stored;
                        end
                        default: s_d.sr = '0;
                    endcase
                end
                st_shift_dr: begin
                    s_d.sr = s_q.sr >> 1;
                    s_d.sr[len - 7'h01] = s_d.tdi_f;
                end
                st_upd_dr: begin
                    unique case (s_q.ir)
                        OP_LA_ADDR_SELECT: s_d.la_addr = s_q.sr[LA_ADDR_W-1:0];
                        OP_LA_DATA_SELECT, OP_LOGIC_COL_READ: begin
                            s_d.la_data = s_q.sr;
                        end
                        OP_CA_ADDR_SELECT: s_d.ca_addr = s_q.sr[CA_ADDR_W-1:0];
                        OP_CA_DATA_SELECT, OP_CFG_COL_READ: begin
                            s_d.ca_data = s_q.sr[CA_DATA_W-1:0];
                        end
                        OP_SIG_SHIFT: s_d.sig = s_q.sr[SIG_W-1:0];
                        default: s_d.sig = s_q.sig;
                    endcase
                end
                default: s_d.rti_cnt = 2'h0;
            endcase
            if (s_q.tap != st_idle && s_q.tap != st_upd_ir) begin
                s_d.rti_cnt = 2'h0;
            end
            // Cleared on entry, so five tms-high rises are enough
            if (s_d.tap == st_reset) begin
                s_d.ir    = OP_IDCODE;
                s_d.prog  = 1'b0;
                s_d.armed = 1'b0;
            end
        end

        // Output changes on the falling edge, after the state has moved
        if (fall) begin
            s_d.tdo_oe_n = ~(s_q.tap == st_shift_ir || s_q.tap == st_shift_dr);
            if (s_q.tap == st_shift_ir) begin
                s_d.tdo = s_q.ir_sr[0];
            end else if (s_q.tap == st_shift_dr) begin
                s_d.tdo = s_q.sr[0];
            end
        end

        // Programming mode alone keeps outputs safe too
        s_d.safe = s_d.prog | holds_safe(s_d.ir);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q <= RESET_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign tdo               = s_q.tdo;
    assign tdo_oe_n          = s_q.tdo_oe_n;
    assign logic_address     = s_q.la_addr;
    assign logic_data        = s_q.la_data;
    assign config_address    = s_q.ca_addr;
    assign config_data       = s_q.ca_data;
    assign user_signature    = s_q.sig;
    assign nvm_op_code       = s_q.op_code;
    assign nvm_op_pulse      = s_q.op_pulse;
    assign programming_mode  = s_q.prog;
    assign outputs_safe_hold = s_q.safe;

endmodule // tap_prog_port

`default_nettype wire

// [verification/tap_prog_port_assertions.sv]
/* Checker for the programming port, bound to its top module.
   Assumes tck holds each level for at least four ref_clk cycles. */
`timescale 1ns/1ns
`default_nettype none
module tap_prog_port_assertions
    import tap_prog_pkg::*;
(
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 reset,
    // Test pins
    input wire logic                 tck,
    input wire logic                 tms,
    input wire logic                 tdo,
    input wire logic                 tdo_oe_n,
    // Memory side
    input wire logic [LA_DATA_W-1:0] logic_data,
    input wire logic [CA_DATA_W-1:0] config_data,
    input wire logic [5:0]           nvm_op_code,
    input wire logic                 nvm_op_pulse,
    // Output control
    input wire logic                 programming_mode,
    input wire logic                 outputs_safe_hold
);
    logic [2:0] high_q;
    logic       prog_op;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    assign prog_op = nvm_op_code inside {6'h03, 6'h04, 6'h05, 6'h06,
                                         6'h0C, 6'h0D, 6'h16, 6'h1D, 6'h1F};
    // Consecutive rises of the tck pin seen with tms high, saturating
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            high_q <= 3'h0;
        end else if (tck && !$past(tck)) begin
            high_q <= !tms ? 3'h0 : (high_q == 3'h7) ? 3'h7 : high_q + 3'h1;
        end
    end
    a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck, 2))
        else $error("tdo moved outside the tck low phase");
    a_oe_on_fall: assert property ($changed(tdo_oe_n) |-> !$past(tck, 2))
        else $error("tdo enable moved outside the tck low phase");
    a_pulse_single: assert property (nvm_op_pulse |=> !nvm_op_pulse)
        else $error("operation pulse longer than one cycle");
    a_pulse_after_rise: assert property (nvm_op_pulse |-> $past(tck, 3))
        else $error("operation fired away from a tck rise");
    a_op_needs_mode: assert property (nvm_op_pulse ##1 prog_op |-> programming_mode)
        else $error("erase or program fired outside programming mode");
    a_mode_keeps_safe: assert property (programming_mode && $past(programming_mode) |-> outputs_safe_hold)
        else $error("programming mode without safe outputs");
    a_tms_high_reset: assert property ($rose(high_q == 3'h5) |-> ##[1:8] (!programming_mode && tdo_oe_n))
        else $error("five tms high rises did not reset the port");
    a_reset_quiet: assert property ($fell(reset) |-> !programming_mode && !outputs_safe_hold && tdo_oe_n && !nvm_op_pulse)
        else $error("port not quiet after reset");
    a_write_on_rise: assert property ($changed(logic_data) || $changed(config_data) |-> $past(tck, 3))
        else $error("data path written away from a tck rise");
endmodule // tap_prog_port_assertions

bind tap_prog_port tap_prog_port_assertions i_chk (
    .ref_clk(ref_clk), .reset(reset), .tck(tck), .tms(tms), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .logic_data(logic_data), .config_data(config_data),
    .nvm_op_code(nvm_op_code), .nvm_op_pulse(nvm_op_pulse),
    .programming_mode(programming_mode),
    .outputs_safe_hold(outputs_safe_hold));
`default_nettype wire

// [verification/tap_programmer_model.sv]
/* Programmer model: drives the test pins and runs scans from idle.
   Assumes ref_clk at 100 MHz; tck runs at 80 ns, still between steps. */
`timescale 1ns/1ns
`default_nettype none
module tap_programmer_model (
    // Clock
    input  wire logic ref_clk,
    // Test pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Pins move at the tck fall, tdo taken late in the high phase
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(negedge ref_clk);
        tck = 1'b1;
        repeat (4) @(negedge ref_clk);
        q = tdo;
        tck = 1'b0;
    endtask
    // Outside shifts tdi toggles so a stale value never looks valid
    task automatic moves(input logic [7:0] pat, input int n);
        logic q;
        for (int i = 0; i < n; i++) step(pat[i], ~tdi, q);
    endtask
    task automatic reset5();
        moves(8'h1F, 5);
        moves(8'h00, 1);
    endtask
    task automatic scan(input logic ir, input int len,
                        input logic [95:0] din, output logic [95:0] dout);
        logic q;
        dout = '0;
        moves(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < len; i++) begin
            step(i == len - 1, din[i], q);
            dout[i] = q;
        end
        moves(8'h01, 2);
    endtask
endmodule // tap_programmer_model
`default_nettype wire

// [verification/testbench.sv]
/* Bench for the programming port: a table of scans per instruction,
   then hand tests. Assumes the programmer model owns the test pins. */
`timescale 1ns/1ns
`default_nettype none
module testbench
    import tap_prog_pkg::*;
();
    localparam logic [ID_W-1:0] ID_EXP = 32'h0000_5A3C; // Arbitrary
    localparam int LIMIT = 60000;
    typedef struct {
        logic [5:0] code;
        int         len;
        logic       safe;
    } row_type;
    logic ref_clk, reset, tck, tms, tdi, tdo, tdo_oe_n, nvm_op_pulse;
    logic programming_mode, outputs_safe_hold;
    logic [STATUS_W-1:0]  status = 12'hA5C;
    logic [LA_DATA_W-1:0] lrd = 81'h1_3579_BDF0_2468_ACE1_F00D;
    logic [CA_DATA_W-1:0] crd = 41'h1_5A5A_C3C3;
    logic [SIG_W-1:0]     sig = 16'hBEE5;
    logic [LA_ADDR_W-1:0] logic_address;
    logic [LA_DATA_W-1:0] logic_data;
    logic [CA_ADDR_W-1:0] config_address;
    logic [CA_DATA_W-1:0] config_data;
    logic [SIG_W-1:0]     user_signature;
    logic [5:0]           nvm_op_code;
    logic [95:0]          din, dout, got, lmask, cmask;
    int bad_count = 0, samples_checked = 0, pulses = 0, cycles = 0;
    row_type r;
    row_type rows [16] = '{'{6'h00, 1, 0}, '{6'h07, 1, 0}, '{6'h1C, 1, 0},
        '{6'h3F, 1, 0}, '{6'h20, 1, 0}, '{6'h0F, 1, 0}, '{6'h10, 1, 0},
        '{6'h01, 75, 1}, '{6'h02, 81, 1}, '{6'h08, 81, 1}, '{6'h0A, 4, 1},
        '{6'h0B, 41, 1}, '{6'h0E, 41, 1}, '{6'h19, 32, 0},
        '{6'h1B, 12, 0}, '{6'h1E, 16, 0}};
    logic [5:0] ops [12] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h0C, 6'h0D,
        6'h16, 6'h1D, 6'h1F, 6'h08, 6'h0E, 6'h09};

    tap_prog_port #(.ID_VALUE(ID_EXP)) i_dut (
        .ref_clk(ref_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe_n(tdo_oe_n), .comparator_status(status),
        .logic_read_data(lrd), .config_read_data(crd),
        .user_signature_stored(sig), .logic_address(logic_address),
        .logic_data(logic_data), .config_address(config_address),
        .config_data(config_data), .user_signature(user_signature),
        .nvm_op_code(nvm_op_code), .nvm_op_pulse(nvm_op_pulse),
        .programming_mode(programming_mode),
        .outputs_safe_hold(outputs_safe_hold));
    tap_programmer_model i_prog (.ref_clk(ref_clk), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (nvm_op_pulse === 1'b1) pulses++;
        if (cycles == LIMIT) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic check(input string name, input logic [95:0] exp,
                         input logic [95:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [95:0] exp_cap(input logic [5:0] c);
        case (c)
            6'h19: return 96'(ID_EXP);
            6'h1B: return 96'(status);
            6'h1E: return 96'(sig);
            6'h02, 6'h08: return 96'(lrd);
            6'h0B, 6'h0E: return 96'(crd);
            default: return '0;
        endcase
    endfunction
    task automatic op_ir(input logic [5:0] c);
        i_prog.scan(1'b1, 6, 96'(c), dout);
    endtask
    task automatic read_id();
        i_prog.scan(1'b0, 40, 96'hC3_1234_5678, dout);
        check("id code", 96'(ID_EXP), dout & 96'hFFFF_FFFF);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("oe after reset", 96'h1, 96'(tdo_oe_n));
        check("mode after reset", 96'h0, 96'(programming_mode));
        i_prog.moves(8'h00, 1);
        read_id();
        $display("test power-up done");
        foreach (rows[k]) begin
            r = rows[k];
            i_prog.scan(1'b1, 6, 96'(r.code), dout);
            check("ir capture", 96'h19, dout);
            check("safe hold", 96'(r.safe), 96'(outputs_safe_hold));
            din = {3{32'h9C3A_65F1}} ^ 96'(k);
            i_prog.scan(1'b0, r.len + 8, din, dout);
            lmask = (96'h1 << r.len) - 96'h1;
            cmask = (r.code inside {6'h01, 6'h0A}) ? '0 : lmask;
            check("capture", exp_cap(r.code) & cmask, dout & cmask);
            check("length", din & 96'hFF, (dout >> r.len) & 96'hFF);
            case (r.code)
                6'h01: got = 96'(logic_address);
                6'h02, 6'h08: got = 96'(logic_data);
                6'h0A: got = 96'(config_address);
                6'h0B, 6'h0E: got = 96'(config_data);
                6'h1E: got = 96'(user_signature);
                // Signature is written by the last row only
                default: got = ((din >> 8) & lmask) | 96'(user_signature);
            endcase
            check("path write", (din >> 8) & lmask, got);
        end
        $display("test instruction table done");
        op_ir(6'h18);
        check("mode enter", 96'h1, 96'(programming_mode));
        foreach (ops[k]) begin
            pulses = 0;
            op_ir(ops[k]);
            check("early pulse", 96'h0, 96'(pulses));
            i_prog.moves(8'h00, 3);
            check("pulse count", 96'h1, 96'(pulses));
            check("op code", 96'(ops[k]), 96'(nvm_op_code));
        end
        $display("test operations done");
        op_ir(6'h1A);
        check("mode exit", 96'h0, 96'(programming_mode));
        check("safe exit", 96'h0, 96'(outputs_safe_hold));
        pulses = 0;
        op_ir(6'h03);
        i_prog.moves(8'h00, 3);
        check("refused pulse", 96'h0, 96'(pulses));
        op_ir(6'h17);
        check("safe state", 96'h1, 96'(outputs_safe_hold));
        check("safe no mode", 96'h0, 96'(programming_mode));
        $display("test refusal done");
        op_ir(6'h18);
        i_prog.moves(8'h01, 3);
        i_prog.reset5();
        check("mode after tms", 96'h0, 96'(programming_mode));
        read_id();
        op_ir(6'h18);
        reset = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("mode in reset", 96'h0, 96'(programming_mode));
        check("oe in reset", 96'h1, 96'(tdo_oe_n));
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        i_prog.moves(8'h00, 1);
        read_id();
        $display("test resets done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
